// ### amp_interrupt_aggregator.sv
// interrupt aggregation: sticky event flags, mask, clip status and interrupt pin drive
`timescale 1ns/1ps

// Functional notes
// - pin style field: 00 high active, 01 low active, 10 open drain low; resets 00.
// - clip trigger type bit: 0 level, 1 edge; resets to 0.
// - edge mode: reading clip status clears every channel clip flag whose clip is no longer active; reset too.
// - mask 1 lets source drive pin; mask 0 blocks pin; masks reset zero.
// - mask positions match flag positions; pin events use separate per-pin mask.
// - each flag in bits 5 down to 3 reads 1 if its condition occurred since the last flags read.
// - reading event flags clears bits 7 down to 3.
// - reading event flags keeps bits 2 and 1; bit 0 reserved.
// - edge mode: clip summary clears by clip read, pin summary by pin status read.
// - level mode: summary holds while level persists; afterwards matching read clears it.
// - converter-lost event on interface error or lost lock.
// - converter-locked event when all active channels are locked.
// - lost and locked flags exclusive; newest state replaces the other.
// - ramp-up event when every active channel finished ramping up.
// - ramp-down event when every active channel finished ramping down.
// - mute event when every muted channel finished its mute ramp.
// - clip summary is OR of per-channel clip flags.
// - pin summary is OR of unmasked supported pin status bits.
// - channel clip flags ignore the clip mask; reads clear only in edge mode.
module amp_interrupt_aggregator
  import amp_irq_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int GP_PINS  = 4
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // control port register access
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // converter state
  input  wire logic                conv_fault,
  input  wire logic [CHANNELS-1:0] conv_locked,
  input  wire logic [CHANNELS-1:0] chan_active,
  // volume ramp state
  input  wire logic [CHANNELS-1:0] ramp_up_finished,
  input  wire logic [CHANNELS-1:0] ramp_down_finished,
  input  wire logic [CHANNELS-1:0] mute_finished,
  input  wire logic [CHANNELS-1:0] chan_muted,
  // output clipping
  input  wire logic [CHANNELS-1:0] clip_active,
  // general-purpose pin status from the pin block
  input  wire logic [GP_PINS-1:0]  gp_status,
  input  wire logic [GP_PINS-1:0]  pin_irq_mask,
  // interrupt pin
  output logic                     irq_out,
  output logic                     irq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0]          pin_mode;
  logic [7:0]          enable_mask;
  logic [7:0]          event_flags;
  logic [CHANNELS-1:0] channel_clip_flag;
  logic [1:0]          irq_pin_style;
  logic                clip_trigger_type;
  logic                rd_flags;
  logic                rd_clip;
  logic                rd_gp;
  logic                lock_ev;
  logic                ramp_up_ev;
  logic                ramp_down_ev;
  logic                mute_ev;
  logic                lost_ev;
  logic                clip_any;
  logic                gp_any;
  logic                pending;
  logic [7:0]          next_rdata;

  assign irq_pin_style     = pin_mode[STYLE_LSB +: 2];
  assign clip_trigger_type = pin_mode[TRIG_BIT];
  assign rd_flags          = reg_rd && (reg_addr == ADDR_EVENT_FLAGS);
  assign rd_clip           = reg_rd && (reg_addr == ADDR_CLIP_STATUS);
  assign rd_gp             = reg_rd && (reg_addr == ADDR_GP_STATUS);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pin_mode <= RST_PIN_MODE;
    else if (reg_wr && reg_addr == ADDR_PIN_MODE)
      pin_mode <= reg_wdata & PIN_MODE_WMASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      enable_mask <= RST_ENABLE_MASK;
    else if (reg_wr && reg_addr == ADDR_ENABLE_MASK)
      enable_mask <= reg_wdata & ENABLE_MASK_WMASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // event sources

  all_done_detect #(.CHANNELS(CHANNELS)) u_lock_det (
    .core_clk (core_clk),
    .rst      (rst),
    .done     (conv_locked),
    .selected (chan_active),
    .rise     (lock_ev)
  );

  all_done_detect #(.CHANNELS(CHANNELS)) u_up_det (
    .core_clk (core_clk),
    .rst      (rst),
    .done     (ramp_up_finished),
    .selected (chan_active),
    .rise     (ramp_up_ev)
  );

  all_done_detect #(.CHANNELS(CHANNELS)) u_down_det (
    .core_clk (core_clk),
    .rst      (rst),
    .done     (ramp_down_finished),
    .selected (chan_active),
    .rise     (ramp_down_ev)
  );

  all_done_detect #(.CHANNELS(CHANNELS)) u_mute_det (
    .core_clk (core_clk),
    .rst      (rst),
    .done     (mute_finished),
    .selected (chan_muted),
    .rise     (mute_ev)
  );

  // the fault input already covers lost frame or master clock and ratio changes
  assign lost_ev = conv_fault;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel clip status, never gated by the clip mask

  always_ff @(posedge core_clk)
  begin
    if (rst)
      channel_clip_flag <= RST_CLIP_STATUS[CHANNELS-1:0];
    else if (clip_trigger_type)
      channel_clip_flag <= (rd_clip ? '0 : channel_clip_flag) | clip_active;
    else
      channel_clip_flag <= clip_active;
  end

  assign clip_any = |channel_clip_flag;
  assign gp_any   = |(gp_status & pin_irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // event flags; a set in the same cycle as a clearing read always wins

  always_ff @(posedge core_clk)
  begin
    if (rst)
      event_flags <= RST_EVENT_FLAGS;
    else
    begin
      // newest converter state replaces the opposite one; a fault beats a lock
      if (lost_ev)
      begin
        event_flags[BIT_CONV_LOST]   <= 1'b1;
        event_flags[BIT_CONV_LOCKED] <= 1'b0;
      end
      else if (lock_ev)
      begin
        event_flags[BIT_CONV_LOST]   <= 1'b0;
        event_flags[BIT_CONV_LOCKED] <= 1'b1;
      end
      else if (rd_flags)
      begin
        event_flags[BIT_CONV_LOST]   <= 1'b0;
        event_flags[BIT_CONV_LOCKED] <= 1'b0;
      end
      event_flags[BIT_RAMP_UP]   <= ramp_up_ev   | (event_flags[BIT_RAMP_UP]   & ~rd_flags);
      event_flags[BIT_RAMP_DOWN] <= ramp_down_ev | (event_flags[BIT_RAMP_DOWN] & ~rd_flags);
      event_flags[BIT_MUTE_DONE] <= mute_ev      | (event_flags[BIT_MUTE_DONE] & ~rd_flags);
      // summaries ignore the flags read and clear only by their own status read
      // in edge mode the clip read empties every channel flag not still clipping, so the summary drops to the OR of clip_active
      event_flags[BIT_CLIP_SUM] <= (clip_trigger_type && rd_clip) ? (|clip_active)
                                 : clip_any | (event_flags[BIT_CLIP_SUM] & ~rd_clip);
      event_flags[BIT_PIN_SUM]  <= gp_any   | (event_flags[BIT_PIN_SUM]  & ~rd_gp);
      event_flags[0]            <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      ADDR_PIN_MODE:    next_rdata = pin_mode;
      ADDR_ENABLE_MASK: next_rdata = enable_mask;
      ADDR_EVENT_FLAGS: next_rdata = event_flags;
      ADDR_CLIP_STATUS: next_rdata = 8'(channel_clip_flag);
      default:          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata  <= reg_rd ? next_rdata : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin; pin summary already carries the per-pin masks

  assign pending = (|(event_flags[7:2] & enable_mask[7:2])) | event_flags[BIT_PIN_SUM];

  // the reserved style code behaves as active high so the pin is never left floating
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b1;
    end
    else
    begin
      unique case (irq_pin_style)
        STYLE_ACT_LOW:
        begin
          irq_out <= ~pending;
          irq_oe  <= 1'b1;
        end
        STYLE_OPEN_DRN:
        begin
          irq_out <= 1'b0;
          irq_oe  <= pending;
        end
        default:
        begin
          irq_out <= pending;
          irq_oe  <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_style_high: assert property (irq_pin_style == STYLE_ACT_HIGH |=> irq_oe && irq_out == $past(pending))
    else $error("active high pin style wrong");
  chk_style_low: assert property (irq_pin_style == STYLE_ACT_LOW |=> irq_oe && irq_out == !$past(pending))
    else $error("active low pin style wrong");
  chk_style_od: assert property (irq_pin_style == STYLE_OPEN_DRN |=> !irq_out && irq_oe == $past(pending))
    else $error("open drain pin style wrong");
  chk_clip_edge_clear: assert property (clip_trigger_type && rd_clip && !(|clip_active) |=> channel_clip_flag == '0)
    else $error("edge clip flags not cleared by read");
  chk_clip_level_follow: assert property (!clip_trigger_type |=> channel_clip_flag == $past(clip_active))
    else $error("level clip flags do not follow source");
  chk_masked_no_pin: assert property (enable_mask[7:2] == 6'h00 && !event_flags[BIT_PIN_SUM]
    && irq_pin_style == STYLE_ACT_HIGH |=> !irq_out)
    else $error("masked source reached pin");
  chk_edge_read_clear: assert property (rd_flags && !lost_ev && !lock_ev
    && !ramp_up_ev && !ramp_down_ev && !mute_ev |=> event_flags[7:3] == 5'h00)
    else $error("edge flags survive status read");
  chk_summary_kept: assert property (rd_flags && event_flags[BIT_CLIP_SUM] |=> event_flags[BIT_CLIP_SUM])
    else $error("clip summary lost on flags read");
  chk_pin_sum_kept: assert property (rd_flags && event_flags[BIT_PIN_SUM] |=> event_flags[BIT_PIN_SUM])
    else $error("pin summary lost on flags read");
  chk_edge_sum_clear: assert property (clip_trigger_type && rd_clip && !(|clip_active) |=> !event_flags[BIT_CLIP_SUM])
    else $error("edge clip summary not cleared by read");
  chk_lock_excl: assert property (!(event_flags[BIT_CONV_LOST] && event_flags[BIT_CONV_LOCKED]))
    else $error("lost and locked both set");
  chk_clip_summary: assert property (clip_any && !(clip_trigger_type && rd_clip) |=> event_flags[BIT_CLIP_SUM])
    else $error("clip summary missing");
  chk_pin_summary: assert property (gp_any |=> event_flags[BIT_PIN_SUM])
    else $error("pin summary not raised");
  chk_pin_sum_irq: assert property (event_flags[BIT_PIN_SUM] && irq_pin_style == STYLE_ACT_HIGH |=> irq_out)
    else $error("pin summary did not reach pin");
  chk_level_hold: assert property (event_flags[BIT_CLIP_SUM] && !rd_clip |=> event_flags[BIT_CLIP_SUM])
    else $error("clip summary dropped without read");
  chk_ramp_sticky: assert property (ramp_up_ev |=> event_flags[BIT_RAMP_UP])
    else $error("ramp up flag not set");

  cov_lock_then_lost: cover property (lock_ev ##[1:20] lost_ev);
  cov_edge_clip_read: cover property (clip_trigger_type && channel_clip_flag != '0 ##1 rd_clip);
  cov_od_assert: cover property (irq_pin_style == STYLE_OPEN_DRN && irq_oe);

endmodule

// ### amp_irq_pkg.sv
// register map, field positions and pin style codes of the amplifier interrupt aggregator
package amp_irq_pkg;

  // register byte addresses on the control port
  localparam logic [7:0] ADDR_PIN_MODE    = 8'h28;
  localparam logic [7:0] ADDR_ENABLE_MASK = 8'h29;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h2A;
  localparam logic [7:0] ADDR_CLIP_STATUS = 8'h2B;
  localparam logic [7:0] ADDR_GP_STATUS   = 8'h2F;

  // interrupt_pin_mode fields
  localparam int STYLE_LSB = 6;
  localparam int TRIG_BIT  = 0;

  // interrupt_event_flags and interrupt_enable_mask bit positions
  localparam int BIT_CONV_LOST   = 7;
  localparam int BIT_CONV_LOCKED = 6;
  localparam int BIT_RAMP_UP     = 5;
  localparam int BIT_RAMP_DOWN   = 4;
  localparam int BIT_MUTE_DONE   = 3;
  localparam int BIT_CLIP_SUM    = 2;
  localparam int BIT_PIN_SUM     = 1;

  // irq_pin_style codes
  localparam logic [1:0] STYLE_ACT_HIGH = 2'h0;
  localparam logic [1:0] STYLE_ACT_LOW  = 2'h1;
  localparam logic [1:0] STYLE_OPEN_DRN = 2'h2;

  // reset values
  localparam logic [7:0] RST_PIN_MODE    = 8'h00;
  localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
  localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RST_CLIP_STATUS = 8'h00;

  // writable bits; reserved bits read as zero
  localparam logic [7:0] PIN_MODE_WMASK    = 8'hC1;
  localparam logic [7:0] ENABLE_MASK_WMASK = 8'hFC;

endpackage

// ### all_done_detect.sv
// pulses once when every selected channel reports done
`timescale 1ns/1ps
module all_done_detect #(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // channel status
  input  wire logic [CHANNELS-1:0] done,
  input  wire logic [CHANNELS-1:0] selected,
  // event out
  output logic                     rise
);

  logic all_now;
  logic all_prev;

  // with no channel selected there is nothing to finish, so no event
  assign all_now = (|selected) && (&(done | ~selected));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      all_prev <= 1'b0;
      rise     <= 1'b0;
    end
    else
    begin
      all_prev <= all_now;
      rise     <= all_now & ~all_prev;
    end
  end

endmodule

// ### amp_host_model.sv
// host processor model: register port driver and interrupt pin sense
`timescale 1ns/1ps
module amp_host_model (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  // interrupt pin
  input  wire logic       irq_out,
  input  wire logic       irq_oe,
  output logic            irq_wire
);
  // a released pin floats to the board pull-up
  assign irq_wire = irq_oe ? irq_out : 1'b1;

  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // one-cycle strobe; idle lines show the inverse so a stale value never looks valid
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    #1;
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = wr;
    reg_rd    = ~wr;
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask

  // the host polls the pin until it shows the wanted level; the wait is bounded to 20 cycles
  task automatic wait_irq(input logic level, output bit seen);
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++)
    begin
      @(posedge core_clk);
      #1;
      seen = (irq_wire === level);
    end
  endtask
endmodule

// ### amp_interrupt_aggregator_tb.sv
// self-checking testbench of the amplifier interrupt aggregator
`timescale 1ns/1ps
module amp_interrupt_aggregator_tb;
  import amp_irq_pkg::*;
  logic       core_clk, rst, reg_wr, reg_rd, reg_rvalid, conv_fault, irq_out, irq_oe, irq_wire;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, conv_locked, chan_active, clip_active, clip_v;
  logic [7:0] ramp_up_finished, ramp_down_finished, mute_finished, chan_muted;
  logic [3:0] gp_status, pin_irq_mask;
  logic [7:0] exp_q[$];
  int         miscompares, total_checks, seed;
  bit         seen;

  amp_interrupt_aggregator i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_fault(conv_fault), .conv_locked(conv_locked), .chan_active(chan_active),
    .ramp_up_finished(ramp_up_finished), .ramp_down_finished(ramp_down_finished),
    .mute_finished(mute_finished), .chan_muted(chan_muted), .clip_active(clip_active),
    .gp_status(gp_status), .pin_irq_mask(pin_irq_mask), .irq_out(irq_out), .irq_oe(irq_oe));
  amp_host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .irq_out(irq_out), .irq_oe(irq_oe), .irq_wire(irq_wire));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // the expectation is queued before the strobe so the monitor always finds it
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp_v);
    exp_q.push_back(exp_v);
    i_host.access(1'b0, addr, 8'h00);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    i_host.access(1'b1, addr, data);
  endtask

  task automatic fault_pulse;
    conv_fault = 1'b1;
    cyc(1);
    conv_fault = 1'b0;
    cyc(3);
  endtask

  task automatic pin_chk(input logic on, input logic [1:0] style);
    check("irq_wire", {7'h00, irq_wire}, {7'h00, (style == STYLE_ACT_LOW || style == STYLE_OPEN_DRN) ? ~on : on});
    check("irq_oe", {7'h00, irq_oe}, {7'h00, (style == STYLE_OPEN_DRN) ? on : 1'b1});
  endtask

  task automatic sweep(input logic on);
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_PIN_MODE, 8'(s) << STYLE_LSB);
      cyc(3);
      pin_chk(on, 2'(s));
    end
    wr(ADDR_PIN_MODE, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////
  always @(negedge core_clk)
    if (reg_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unrequested reg_rvalid", 8'h01, 8'h00);
      else
        check("reg_rdata", reg_rdata, exp_q.pop_front());
    end

  initial
  begin
    #(100 * 4000);
    check("watchdog", 8'h01, 8'h00);
    results;
  end

  initial
  begin
    seed = 31276;
    rst = 1'b1;
    conv_fault = 1'b0;
    conv_locked = 8'h00;
    chan_active = 8'h0F;
    chan_muted = 8'h03;
    {ramp_up_finished, ramp_down_finished, mute_finished, clip_active} = '0;
    gp_status = 4'h0;
    pin_irq_mask = 4'h0;
    cyc(8);
    rst = 1'b0;
    pin_chk(1'b0, STYLE_ACT_HIGH);
    rd(ADDR_PIN_MODE, 8'h00);
    rd(ADDR_ENABLE_MASK, 8'h00);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    rd(ADDR_CLIP_STATUS, 8'h00);
    rd(8'h40, 8'h00);
    wr(ADDR_ENABLE_MASK, 8'hFF);
    rd(ADDR_ENABLE_MASK, 8'hFC);
    wr(ADDR_PIN_MODE, 8'hFF);
    rd(ADDR_PIN_MODE, 8'hC1);
    wr(ADDR_PIN_MODE, 8'h00);
    // converter lost and read out, then a second loss is replaced by lock before the next read
    fault_pulse();
    i_host.wait_irq(1'b1, seen);
    check("irq seen", {7'h00, seen}, 8'h01);
    rd(ADDR_EVENT_FLAGS, 8'h80);
    fault_pulse();
    conv_locked = 8'h0F;
    cyc(4);
    rd(ADDR_EVENT_FLAGS, 8'h40);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    // lock first, then a fault replaces it
    conv_locked = 8'h00;
    cyc(2);
    conv_locked = 8'h0F;
    cyc(4);
    fault_pulse();
    rd(ADDR_EVENT_FLAGS, 8'h80);
    // one active channel still ramping: no event yet
    ramp_up_finished = 8'h07;
    cyc(4);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      ramp_up_finished = (k == 0) ? (chan_active | 8'($random(seed))) : 8'h00;
      ramp_down_finished = (k == 1) ? (chan_active | 8'($random(seed))) : 8'h00;
      mute_finished = (k == 2) ? (chan_muted | 8'($random(seed))) : 8'h00;
      cyc(4);
      rd(ADDR_EVENT_FLAGS, 8'h20 >> k);
    end
    // a masked source still reaches the flags but not the pin
    wr(ADDR_ENABLE_MASK, 8'h00);
    fault_pulse();
    pin_chk(1'b0, STYLE_ACT_HIGH);
    rd(ADDR_EVENT_FLAGS, 8'h80);
    wr(ADDR_ENABLE_MASK, 8'hFC);
    // clipping in level mode follows the source
    clip_v = 8'($random(seed)) | 8'h01;
    clip_active = clip_v;
    cyc(3);
    rd(ADDR_CLIP_STATUS, clip_v);
    rd(ADDR_EVENT_FLAGS, 8'h04);
    clip_active = 8'h00;
    cyc(2);
    rd(ADDR_EVENT_FLAGS, 8'h04);
    rd(ADDR_CLIP_STATUS, 8'h00);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    // clipping in edge mode is sticky until the clip status read
    wr(ADDR_PIN_MODE, 8'h01);
    clip_active = 8'h30;
    cyc(1);
    clip_active = 8'h00;
    cyc(3);
    rd(ADDR_CLIP_STATUS, 8'h30);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    rd(ADDR_CLIP_STATUS, 8'h00);
    // a reset in mid-run empties sticky clip flags and the mode register
    clip_active = 8'h05;
    {conv_locked, mute_finished} = '0;
    cyc(1);
    clip_active = 8'h00;
    cyc(2);
    pin_chk(1'b1, STYLE_ACT_HIGH);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd(ADDR_CLIP_STATUS, 8'h00);
    rd(ADDR_PIN_MODE, 8'h00);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    // pin events, gated only by the per-pin mask
    pin_irq_mask = 4'h1;
    gp_status = 4'h1;
    cyc(3);
    rd(ADDR_EVENT_FLAGS, 8'h02);
    rd(ADDR_EVENT_FLAGS, 8'h02);
    sweep(1'b1);
    gp_status = 4'h0;
    cyc(2);
    rd(ADDR_GP_STATUS, 8'h00);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    sweep(1'b0);
    pin_irq_mask = 4'h0;
    gp_status = 4'h2;
    cyc(3);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    gp_status = 4'h0;
    cyc(4);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    results;
  end
endmodule
